// *** rtl/cacd_top.sv ***
// converter and auxiliary clock dividers with apb register access
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module cacd_top #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              arst_n_in,
   // apb slave
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]       pwdata_in,
   input  wire logic [3:0]        pstrb_in,
   output logic [31:0]            prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   // converter clock enables
   output logic                   conv_tick_out,
   output logic                   dac_tick_out,
   output logic                   adc_tick_out,
   output logic                   adc_oversample_out,
   // auxiliary clock enables
   output logic                   classd_tick_out,
   output logic                   classd_switch_out,
   output logic                   servo_tick_out,
   output logic                   hk_tick_out
);
   localparam int RW = cacd_pkg::RATIO_W;

   // ==========================================
   // ratio tables
   // class d codes, twice the divide figure
   function automatic logic [RW-1:0] classd_ratio2(input logic [2:0] code);
      case (code)
         3'h0:    classd_ratio2 = 8'h02;
         3'h1:    classd_ratio2 = 8'h04;
         3'h2:    classd_ratio2 = 8'h06;
         3'h3:    classd_ratio2 = 8'h08;
         3'h4:    classd_ratio2 = 8'h0C;
         3'h5:    classd_ratio2 = 8'h10;
         3'h6:    classd_ratio2 = 8'h18;
         default: classd_ratio2 = 8'h20;
      endcase
   endfunction : classd_ratio2

   // servo codes, twice the divide figure; unlisted codes act as /8
   function automatic logic [RW-1:0] servo_ratio2(input logic [3:0] code);
      case (code)
         4'h0:    servo_ratio2 = 8'h02;
         4'h1:    servo_ratio2 = 8'h03;
         4'h2:    servo_ratio2 = 8'h04;
         4'h3:    servo_ratio2 = 8'h05;
         4'h4:    servo_ratio2 = 8'h06;
         4'h5:    servo_ratio2 = 8'h08;
         4'h6:    servo_ratio2 = 8'h0B;
         4'h7:    servo_ratio2 = 8'h0C;
         default: servo_ratio2 = 8'h10;
      endcase
   endfunction : servo_ratio2

   // ==========================================
   // control registers
   logic [2:0] classd_div;
   logic       osr;
   logic       conv_enable;
   logic [3:0] servo_div;
   logic       mode;
   logic [5:0] hk_div;
   logic       quarter;

   // ==========================================
   // apb decode
   logic [7:0]  idx;
   logic        mapped;
   logic        wr_go;
   logic [15:0] wdata;
   logic [15:0] rd_word;

   // word index; byte offset bits and high address bits must be zero
   assign idx = paddr_in[9:2];
   always_comb begin
      mapped = (paddr_in[1:0] == 2'h0) && (paddr_in[ADDR_W-1:10] == '0) &&
               (idx == cacd_pkg::IDX_CFG_ONE || idx == cacd_pkg::IDX_ADC_CTRL ||
                idx == cacd_pkg::IDX_CFG_THREE || idx == cacd_pkg::IDX_CFG_FOUR ||
                idx == cacd_pkg::IDX_STATUS);
   end

   // a write lands only at the completing access edge
   assign wr_go = psel_in && penable_in && pready_out && pwrite_in && mapped;

   // low two byte lanes carry the sixteen register bits
   assign wdata = pwdata_in[15:0];

   // ==========================================
   // effective settings
   logic [2:0]    eff_classd;
   logic [3:0]    eff_servo;
   logic [5:0]    eff_hk;
   logic          eff_quarter;
   logic [RW-1:0] classd_r2;
   logic [RW-1:0] servo_r2;
   logic [RW-1:0] hk_r2;

   // automatic mode overrides every divider field
   always_comb begin
      eff_classd  = mode ? classd_div : cacd_pkg::AUTO_CLASSD;
      eff_servo   = mode ? servo_div : cacd_pkg::AUTO_SERVO;
      eff_hk      = mode ? hk_div : cacd_pkg::AUTO_HK;
      eff_quarter = mode ? quarter : cacd_pkg::AUTO_QUARTER;
   end

   // ratios in half steps for the shared divider
   always_comb begin
      classd_r2 = classd_ratio2(eff_classd);
      servo_r2  = servo_ratio2(eff_servo);
      hk_r2     = {1'b0, eff_hk, 1'b0} + RW'(2);
   end

   // read mux, reserved bits read zero
   always_comb begin
      rd_word = 16'h0000;
      case (idx)
         cacd_pkg::IDX_CFG_ONE: begin
            rd_word[cacd_pkg::CLASSD_LSB +: cacd_pkg::CLASSD_W] = classd_div;
         end
         cacd_pkg::IDX_ADC_CTRL: begin
            rd_word[cacd_pkg::OSR_BIT] = osr;
         end
         cacd_pkg::IDX_CFG_THREE: begin
            rd_word[cacd_pkg::CONV_EN_BIT]                      = conv_enable;
            rd_word[cacd_pkg::SERVO_LSB +: cacd_pkg::SERVO_W]   = servo_div;
         end
         cacd_pkg::IDX_CFG_FOUR: begin
            rd_word[cacd_pkg::MODE_BIT]                         = mode;
            rd_word[cacd_pkg::HK_LSB +: cacd_pkg::HK_W]         = hk_div;
            rd_word[cacd_pkg::QUARTER_BIT]                      = quarter;
         end
         cacd_pkg::IDX_STATUS: begin
            rd_word = {eff_quarter, classd_switch_out, mode, eff_hk, eff_servo,
                       eff_classd};
         end
         default: begin
            rd_word = 16'h0000;
         end
      endcase
   end

   // ==========================================
   // apb answer, one access cycle, data caught in the setup cycle
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
      end else begin
         pready_out  <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in && !mapped;
         if (psel_in && !penable_in && !pwrite_in && mapped) begin
            prdata_out <= {16'h0000, rd_word};
         end else begin
            prdata_out <= 32'h0000_0000;
         end
      end
   end

   // ==========================================
   // register writes, byte strobes select the two low lanes
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         classd_div  <= cacd_pkg::CLASSD_RST;
         osr         <= cacd_pkg::OSR_RST;
         conv_enable <= cacd_pkg::CONV_EN_RST;
         servo_div   <= cacd_pkg::SERVO_RST;
         mode        <= cacd_pkg::MODE_RST;
         hk_div      <= cacd_pkg::HK_RST;
         quarter     <= cacd_pkg::QUARTER_RST;
      end else if (wr_go) begin
         case (idx)
            cacd_pkg::IDX_CFG_ONE: begin
               if (pstrb_in[0] && pstrb_in[1]) begin
                  classd_div <= wdata[cacd_pkg::CLASSD_LSB +: cacd_pkg::CLASSD_W];
               end else if (pstrb_in[0]) begin
                  classd_div[1:0] <= wdata[7:6];
               end else if (pstrb_in[1]) begin
                  classd_div[2] <= wdata[8];
               end
            end
            cacd_pkg::IDX_ADC_CTRL: begin
               if (pstrb_in[1]) begin
                  osr <= wdata[cacd_pkg::OSR_BIT];
               end
            end
            cacd_pkg::IDX_CFG_THREE: begin
               if (pstrb_in[0]) begin
                  conv_enable <= wdata[cacd_pkg::CONV_EN_BIT];
               end
               if (pstrb_in[1]) begin
                  servo_div <= wdata[cacd_pkg::SERVO_LSB +: cacd_pkg::SERVO_W];
               end
            end
            cacd_pkg::IDX_CFG_FOUR: begin
               if (pstrb_in[0]) begin
                  mode   <= wdata[cacd_pkg::MODE_BIT];
                  hk_div <= wdata[cacd_pkg::HK_LSB +: cacd_pkg::HK_W];
               end
               if (pstrb_in[1]) begin
                  quarter <= wdata[cacd_pkg::QUARTER_BIT];
               end
            end
            default: begin
               classd_div <= classd_div;
            end
         endcase
      end
   end

   // ==========================================
   // auxiliary dividers
   cacd_divider #(.RW(RW)) u_classd (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .ratio2_in (classd_r2),
      .tick_out  (classd_tick_out)
   );

   cacd_divider #(.RW(RW)) u_servo (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .ratio2_in (servo_r2),
      .tick_out  (servo_tick_out)
   );

   cacd_divider #(.RW(RW)) u_hk (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .ratio2_in (hk_r2),
      .tick_out  (hk_tick_out)
   );

   // output stage halves the class d clock into a switching level
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         classd_switch_out <= 1'b0;
      end else if (classd_tick_out) begin
         classd_switch_out <= !classd_switch_out;
      end
   end

   // ==========================================
   // converter clock and its adc and dac branches
   logic [1:0] qcnt;
   logic       ahalf;

   // the converter clock runs from system clock only while enabled
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         conv_tick_out <= 1'b0;
      end else begin
         conv_tick_out <= conv_enable;
      end
   end

   // dac branch: every converter tick, or every fourth one
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         qcnt         <= 2'h0;
         dac_tick_out <= 1'b0;
      end else begin
         if (conv_enable) begin
            qcnt <= qcnt + 2'h1;
         end
         if (eff_quarter) begin
            dac_tick_out <= conv_enable && (qcnt == cacd_pkg::QUARTER_LAST);
         end else begin
            dac_tick_out <= conv_enable;
         end
      end
   end

   // adc branch: 128x takes every tick, 64x every other one
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ahalf              <= 1'b0;
         adc_tick_out       <= 1'b0;
         adc_oversample_out <= cacd_pkg::OSR_RST;
      end else begin
         adc_oversample_out <= osr;
         if (conv_enable) begin
            ahalf <= !ahalf;
         end
         adc_tick_out <= conv_enable && (osr || ahalf);
      end
   end

   // ==========================================
   // checks
   logic [RW-1:0] cd_gap;
   logic [RW-1:0] cd_r2_q;
   logic          cd_seen;

   // cycles between class d ticks; a ratio change voids the running period
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cd_gap  <= '0;
         cd_r2_q <= '0;
         cd_seen <= 1'b0;
      end else begin
         cd_r2_q <= classd_r2;
         if (classd_tick_out) begin
            cd_gap <= RW'(1);
         end else begin
            cd_gap <= cd_gap + RW'(1);
         end
         if (classd_r2 != cd_r2_q) begin
            cd_seen <= 1'b0;
         end else if (classd_tick_out) begin
            cd_seen <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   auto_ignore_a: assert property (
      !mode |-> (classd_r2 == 8'h20) && (servo_r2 == 8'h10) && (hk_r2 == 8'h60))
      else $error("automatic mode honoured a divider field");
   auto_quarter_a: assert property (
      !mode && $past(!mode) && dac_tick_out |=> !dac_tick_out [*3])
      else $error("automatic mode dac rate not quarter");
   classd_gap_a: assert property (
      classd_tick_out && cd_seen && $stable(classd_r2) |-> cd_gap <= (classd_r2 >> 1))
      else $error("class d period too long");
   switch_half_a: assert property (
      classd_tick_out |=> classd_switch_out != $past(classd_switch_out))
      else $error("switching level missed a class d tick");
   switch_hold_a: assert property (
      !classd_tick_out |=> $stable(classd_switch_out))
      else $error("switching level moved without a tick");
   servo_gap_a: assert property (
      servo_tick_out && mode && servo_div == 4'h1 && $past(servo_div) == 4'h1
      |-> ##[1:2] servo_tick_out)
      else $error("servo one and a half ratio gap wrong");
   hk_ratio_a: assert property (
      mode |-> hk_r2 == {1'b0, hk_div, 1'b0} + 8'h02)
      else $error("housekeeping ratio is not field plus one");
   conv_gate_a: assert property (
      !conv_enable |=> !conv_tick_out && !dac_tick_out && !adc_tick_out)
      else $error("converter clock ran while disabled");
   conv_run_a: assert property (
      conv_enable [*2] |-> conv_tick_out)
      else $error("converter clock idle while enabled");
   adc_half_a: assert property (
      conv_enable && !osr && !$past(osr) && adc_tick_out |=> !adc_tick_out)
      else $error("64x adc rate ticks back to back");
   adc_full_a: assert property (
      $past(osr) && $past(conv_enable) |-> adc_tick_out)
      else $error("128x adc rate dropped a tick");
   mode_write_a: assert property (
      wr_go && idx == cacd_pkg::IDX_CFG_FOUR && pstrb_in[0]
      |=> mode == $past(wdata[cacd_pkg::MODE_BIT]))
      else $error("mode bit did not take the write");
   dac_direct_a: assert property (
      $past(!eff_quarter) |-> dac_tick_out == conv_tick_out)
      else $error("dac branch divided while quarter off");
   apb_answer_a: assert property (
      psel_in && !penable_in |=> pready_out ##1 !pready_out)
      else $error("apb answer not one cycle");
endmodule : cacd_top

// *** rtl/cacd_pkg.sv ***
// constants for the converter and auxiliary clock dividers
// How it works
// - adc oversample bit set gives 128x, cleared gives 64x with less power
// - class d, servo and housekeeping fields act only in manual mode
// - in automatic mode ignored fields, dac quarter select too, change nothing
// - class d field divides system clock by 1,2,3,4,6,8,12,16
// - output stage halves the class d clock again for switching
// - servo field divides by 1,1.5,2,2.5,3,4,5.5,6,8
// - housekeeping field divides by value plus one, 1 to 64
// - converter clock enable bit gates the converter clock
// - converter clock comes from system clock and feeds adc and dac
// - mode bit: 0 automatic, 1 manual, reset value 1
// - dac quarter bit set divides dac clock by four more
package cacd_pkg;
   // ==========================================
   // register indices, byte address is four times the index
   localparam logic [7:0]  IDX_CFG_ONE     = 8'h06;
   localparam logic [7:0]  IDX_ADC_CTRL    = 8'h0E;
   localparam logic [7:0]  IDX_CFG_THREE   = 8'h41;
   localparam logic [7:0]  IDX_CFG_FOUR    = 8'h42;
   localparam logic [7:0]  IDX_STATUS      = 8'h43;
   localparam int          REG_W           = 16;
   // ==========================================
   // field positions
   localparam int          CLASSD_LSB      = 6;
   localparam int          CLASSD_W        = 3;
   localparam int          OSR_BIT         = 9;
   localparam int          CONV_EN_BIT     = 0;
   localparam int          SERVO_LSB       = 10;
   localparam int          SERVO_W         = 4;
   localparam int          MODE_BIT        = 0;
   localparam int          HK_LSB          = 1;
   localparam int          HK_W            = 6;
   localparam int          QUARTER_BIT     = 9;
   // ==========================================
   // reset values
   localparam logic [2:0]  CLASSD_RST      = 3'h7;
   localparam logic        OSR_RST         = 1'h1;
   localparam logic        CONV_EN_RST     = 1'h0;
   localparam logic [3:0]  SERVO_RST       = 4'h8;
   localparam logic        MODE_RST        = 1'h1;
   localparam logic [5:0]  HK_RST          = 6'h2F;
   localparam logic        QUARTER_RST     = 1'h1;
   // ==========================================
   // settings the block uses by itself in automatic mode
   localparam logic [2:0]  AUTO_CLASSD     = 3'h7;
   localparam logic [3:0]  AUTO_SERVO      = 4'h8;
   localparam logic [5:0]  AUTO_HK         = 6'h2F;
   localparam logic        AUTO_QUARTER    = 1'h1;
   // ==========================================
   // divider ratio width, ratios held as twice the divide figure
   localparam int          RATIO_W         = 8;
   localparam logic [1:0]  QUARTER_LAST    = 2'h3;
endpackage : cacd_pkg

// *** rtl/cacd_divider.sv ***
// fractional clock enable divider, ratio given in half steps
`timescale 1ns/1ps
module cacd_divider #(
   parameter int RW = 8
) (
   // clock and reset
   input  wire logic          clk_in,
   input  wire logic          arst_n_in,
   // ratio, twice the divide figure, at least 2
   input  wire logic [RW-1:0] ratio2_in,
   // one cycle enable per divided period
   output logic               tick_out
);
   logic [RW-1:0] acc;
   logic [RW:0]   sum;
   logic [RW:0]   rem;
   logic [RW:0]   rat;

   // each cycle adds two half steps; a tick takes a whole period out
   always_comb begin
      rat = (ratio2_in < 2) ? (RW+1)'(2) : {1'b0, ratio2_in};
      sum = {1'b0, acc} + (RW+1)'(2);
      rem = sum - rat;
   end

   // odd ratios leave a remainder, so periods alternate floor and ceiling
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         acc      <= '0;
         tick_out <= 1'b0;
      end else if (sum >= rat) begin
         acc      <= (rem >= rat) ? '0 : rem[RW-1:0];
         tick_out <= 1'b1;
      end else begin
         acc      <= sum[RW-1:0];
         tick_out <= 1'b0;
      end
   end

   // ==========================================
   // period checking
   logic [RW-1:0] gap;
   logic [RW-1:0] last_gap;
   logic [RW-1:0] ratio_q;
   logic          chg;
   logic          chg_prev;
   logic          ok;

   // cycles since the last tick and whether the ratio moved meanwhile
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         gap      <= '0;
         last_gap <= '0;
         ratio_q  <= '0;
         chg      <= 1'b1;
         chg_prev <= 1'b1;
      end else begin
         ratio_q <= ratio2_in;
         if (tick_out) begin
            gap      <= RW'(1);
            last_gap <= gap;
            chg      <= (ratio2_in != ratio_q);
            chg_prev <= chg;
         end else begin
            gap <= gap + RW'(1);
            chg <= chg | (ratio2_in != ratio_q);
         end
      end
   end

   assign ok = !chg && !chg_prev && (ratio2_in == ratio_q) && (ratio2_in >= 2);

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   even_period_a: assert property (
      tick_out && ok && !ratio2_in[0] |-> gap == (ratio2_in >> 1))
      else $error("whole ratio period is wrong");
   half_pair_a: assert property (
      tick_out && ok && ratio2_in[0] |-> ({1'b0, gap} + {1'b0, last_gap}) == {1'b0, ratio2_in})
      else $error("half ratio periods do not pair up");
endmodule : cacd_divider

// *** verif/cacd_top_tb_top.sv ***
// self-checking testbench for the converter and auxiliary clock dividers
`timescale 1ns/1ps
module cacd_top_tb_top;
   // ==========================================
   // clock, reset and design connections
   logic        clk_in;
   logic        arst_n_in;
   logic        psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr;
   logic        conv_tick, dac_tick, adc_tick, adc_osr, classd_tick, classd_sw, servo_tick, hk_tick;
   int          err_count;
   int          checks_done;
   int          cycles;
   int          g, g2, k;
   logic        s;
   logic [31:0] rdv;
   logic        erv;
   // byte addresses are four times the register index
   localparam logic [11:0] A_ONE   = {2'b00, cacd_pkg::IDX_CFG_ONE, 2'b00};
   localparam logic [11:0] A_ADC   = {2'b00, cacd_pkg::IDX_ADC_CTRL, 2'b00};
   localparam logic [11:0] A_THREE = {2'b00, cacd_pkg::IDX_CFG_THREE, 2'b00};
   localparam logic [11:0] A_FOUR  = {2'b00, cacd_pkg::IDX_CFG_FOUR, 2'b00};
   int classd_div[8] = '{1, 2, 3, 4, 6, 8, 12, 16};
   int servo_half[9] = '{2, 3, 4, 5, 6, 8, 11, 12, 16};
   logic [5:0] hk_code[4] = '{6'h00, 6'h01, 6'h2F, 6'h3F};

   cacd_top u_dut (
      .clk_in(clk_in), .arst_n_in(arst_n_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .conv_tick_out(conv_tick), .dac_tick_out(dac_tick),
      .adc_tick_out(adc_tick), .adc_oversample_out(adc_osr),
      .classd_tick_out(classd_tick), .classd_switch_out(classd_sw),
      .servo_tick_out(servo_tick), .hk_tick_out(hk_tick)
   );

   // 50 MHz system clock
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   // hang guard, far above the length of the whole run
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         err_count++;
         $display("MISMATCH at %0t: run did not finish", $time);
         results();
      end
   end

   // ==========================================
   // verdict and end of run
   task automatic results();
      $display("comparisons %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask : chk

   // ==========================================
   // apb transfer: setup, then access until pready
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk_in);
      penable <= 1'b1;
      do begin
         @(posedge clk_in);
      end while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(negedge clk_in);
   endtask : xfer

   task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic ee);
      xfer(1'b0, a, 32'h0000_0000);
      chk(rdv & m, e, "read data");
      chk({31'h0, erv}, {31'h0, ee}, "slave error");
   endtask : rdchk

   function automatic logic tick_of(input int i);
      case (i)
         0:       return conv_tick;
         1:       return dac_tick;
         2:       return adc_tick;
         3:       return classd_tick;
         4:       return servo_tick;
         default: return hk_tick;
      endcase
   endfunction : tick_of

   // cycles from one tick to the next, sampled at the falling edge; a tick
   // standing now starts the count, so two calls give adjacent periods
   task automatic gap(input int i, output int gg);
      int n;
      n = 0;
      while (tick_of(i) !== 1'b1 && n < 300) begin
         @(negedge clk_in);
         n++;
      end
      gg = 0;
      do begin
         @(negedge clk_in);
         gg++;
      end while (tick_of(i) !== 1'b1 && gg < 300);
   endtask : gap

   // settle after a change, then compare one period
   task automatic per(input int i, input int e, input string what);
      gap(i, g);
      gap(i, g);
      gap(i, g);
      chk(g, e, what);
   endtask : per

   function automatic logic [31:0] four(input logic md, input logic [5:0] hk, input logic q);
      return {22'h0, q, 2'b00, hk, md};
   endfunction : four

   // ==========================================
   // main sequence
   initial begin
      err_count = 0;
      checks_done = 0;
      cycles = 0;
      arst_n_in = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (8) @(posedge clk_in);
      arst_n_in <= 1'b1;
      @(negedge clk_in);
      chk({31'h0, adc_osr}, 32'h1, "oversample level at reset");
      rdchk(A_ONE, 32'h01C0, 32'h01C0, 1'b0);
      rdchk(A_ADC, 32'h0200, 32'h0200, 1'b0);
      rdchk(A_THREE, 32'h3C01, 32'h2000, 1'b0);
      rdchk(A_FOUR, 32'h027F, 32'h025F, 1'b0);
      rdchk(12'h000, 32'hFFFF_FFFF, 32'h0, 1'b1);
      rdchk(A_ONE + 12'h001, 32'hFFFF_FFFF, 32'h0, 1'b1);
      // converter clock stays gated while the enable bit is clear
      g = 0;
      repeat (20) begin
         @(negedge clk_in);
         g += conv_tick + dac_tick + adc_tick;
      end
      chk(g, 0, "gated converter ticks");
      // class d codes in manual mode, switching level halves the rate
      for (k = 0; k < 8; k++) begin
         xfer(1'b1, A_ONE, k << 6);
         rdchk(A_ONE, 32'h01C0, k << 6, 1'b0);
         per(3, classd_div[k], "class d period");
         s = classd_sw;
         @(negedge clk_in);
         chk({31'h0, classd_sw}, {31'h0, ~s}, "switching level toggle");
      end
      // servo codes, half ratios alternate the neighbouring counts
      for (k = 0; k < 9; k++) begin
         xfer(1'b1, A_THREE, k << 10);
         gap(4, g);
         gap(4, g);
         gap(4, g);
         gap(4, g2);
         chk(g + g2, servo_half[k], "servo two periods");
         chk((2 * g >= servo_half[k] - 1) && (2 * g <= servo_half[k] + 1), 1, "servo step");
      end
      for (k = 0; k < 4; k++) begin
         xfer(1'b1, A_FOUR, four(1'b1, hk_code[k], 1'b1));
         per(5, hk_code[k] + 1, "housekeeping period");
      end
      // converter clock enabled, quarter and oversample choices
      xfer(1'b1, A_THREE, 32'h0000_0001);
      per(0, 1, "converter period");
      per(1, 4, "dac quarter period");
      per(2, 1, "adc 128x period");
      xfer(1'b1, A_ADC, 32'h0000_0000);
      per(2, 2, "adc 64x period");
      chk({31'h0, adc_osr}, 32'h0, "oversample level");
      xfer(1'b1, A_FOUR, four(1'b1, 6'h2F, 1'b0));
      per(1, 1, "dac direct period");
      // automatic mode ignores the divider fields
      xfer(1'b1, A_ONE, 32'h0000_0000);
      xfer(1'b1, A_FOUR, four(1'b0, 6'h00, 1'b0));
      per(3, 16, "auto class d period");
      gap(4, g);
      gap(4, g2);
      chk(g + g2, 16, "auto servo periods");
      per(5, 48, "auto housekeeping period");
      per(1, 4, "auto dac period");
      per(2, 2, "auto adc period");
      results();
   end
endmodule : cacd_top_tb_top
